// ### shared/bfps_pkg.sv
// Constants and carrier types for the two-channel pixel sum node
package bfps_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int ADC_W     = 12;
    localparam int WORD_W    = 32;
    localparam int PIX_W     = 16;
    localparam int IDX_W     = 13;
    localparam int NCH       = 2;
    localparam int NPIX      = 5000;
    localparam int NPOINTS   = 10000;
    localparam int NWORDS    = NPOINTS / 2;
    localparam int NBANK     = 2;
    localparam int FIFO_DEP  = 4;
    // ****************************************
    // Field positions, rotation shift and saturation limits
    // ****************************************
    localparam int I_LSB     = 0;
    localparam int Q_LSB     = 16;
    localparam int ROT_SHIFT = 11;
    localparam logic [PIX_W-1:0] PIX_MAX = 16'h7fff;
    localparam logic [PIX_W-1:0] PIX_MIN = 16'h8000;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS    = 10;
    localparam int FRAME_US  = 200;
    localparam int FRAME_CYC = (FRAME_US * 1000) / CLK_NS;

    typedef struct packed {
        logic             first;
        logic [PIX_W-1:0] pix;
    } bfps_pix_t;

    typedef struct packed {
        logic [PIX_W-1:0] q;
        logic [PIX_W-1:0] i;
    } bfps_cplx_t;

    typedef struct packed {
        logic              fine;
        logic              chan;
        logic [IDX_W-1:0]  addr;
        logic [WORD_W-1:0] data;
    } bfps_tbl_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_ROT   = 2'b10,
        ST_DONE  = 2'b11
    } bfps_st_t;
endpackage

// ### hdl/bfps_node.sv
// Pixel sum node: converter packing, sample banks, phase rotation, two summing stages
`timescale 1ns/100ps

// ****************************************
// Synchronous FIFO
// ****************************************
module bfps_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 4
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         clkEn,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0]   count_r;
    logic          push;
    logic          pop;

    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // One word per cycle each side, full rate both ways
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (clkEn) begin
            if (push) begin
                mem_r[wrPtr_r] <= inData;
                wrPtr_r        <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ****************************************
// Node top
// ****************************************
module bfps_node #(
    parameter int FRAME_CYCLES = bfps_pkg::FRAME_CYC,
    parameter int DEPTH        = bfps_pkg::FIFO_DEP
) (
    input  wire logic                            clk,
    input  wire logic                            srst,
    input  wire logic                            clkEn,
    input  wire logic                            adcStrobe,
    input  wire logic [bfps_pkg::ADC_W-1:0]      adcSampA,
    input  wire logic [bfps_pkg::ADC_W-1:0]      adcSampB,
    input  wire logic                            tblWe,
    input  wire bfps_pkg::bfps_tbl_t             tbl,
    input  wire logic                            upValid,
    output logic                                 upReady,
    input  wire bfps_pkg::bfps_pix_t             upPix,
    output logic                                 dnValid,
    input  wire logic                            dnReady,
    output bfps_pkg::bfps_pix_t                  dnPix,
    output logic                                 adcOverflow,
    output logic                                 alignErr,
    output logic                                 frameOverrun,
    output logic                                 tblLocked,
    output logic                                 frameBusy
);
    import bfps_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [PIX_W-1:0] satAdd(input logic [PIX_W-1:0] a, input logic [PIX_W-1:0] b);
        logic signed [PIX_W:0] s;
        s = $signed({a[PIX_W-1], a}) + $signed({b[PIX_W-1], b});
        if (s[PIX_W] != s[PIX_W-1]) begin
            satAdd = s[PIX_W] ? PIX_MIN : PIX_MAX;
        end else begin
            satAdd = s[PIX_W-1:0];
        end
    endfunction

    function automatic logic [PIX_W-1:0] sat29(input logic signed [28:0] x);
        logic signed [28:0] y;
        y = x >>> ROT_SHIFT;
        if (y > $signed({13'h0000, PIX_MAX})) begin
            sat29 = PIX_MAX;
        end else if (y < -$signed({13'h0000, PIX_MAX}) - 29'sd1) begin
            sat29 = PIX_MIN;
        end else begin
            sat29 = y[PIX_W-1:0];
        end
    endfunction

    // I' = I cos - Q sin, Q' = I sin + Q cos
    function automatic bfps_cplx_t rotate(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] f);
        logic signed [28:0] i;
        logic signed [28:0] q;
        logic signed [28:0] c;
        logic signed [28:0] s;
        i = 29'($signed(w[I_LSB +: ADC_W]));
        q = 29'($signed(w[Q_LSB +: ADC_W]));
        c = 29'($signed(f[Q_LSB +: PIX_W]));
        s = 29'($signed(f[I_LSB +: PIX_W]));
        rotate.i = sat29(i * c - q * s);
        rotate.q = sat29(i * s + q * c);
    endfunction

    // Out-of-range coarse entries clamp to the last stored word
    function automatic int memIdx(input logic bank, input logic [IDX_W-1:0] addr);
        int a;
        a = (int'(addr) >= NWORDS) ? NWORDS - 1 : int'(addr);
        memIdx = int'(bank) * NWORDS + a;
    endfunction

    // ****************************************
    // Converter pin synchronisers
    // ****************************************
    logic             strbS1_r;
    logic             strbS2_r;
    logic             strbS3_r;
    logic [ADC_W-1:0] dataS1_r [NCH];
    logic [ADC_W-1:0] dataS2_r [NCH];
    logic             sampTick;

    always_ff @(posedge clk) begin
        if (srst) begin
            strbS1_r <= 1'b0;
            strbS2_r <= 1'b0;
            strbS3_r <= 1'b0;
        end else if (clkEn) begin
            strbS1_r    <= adcStrobe;
            strbS2_r    <= strbS1_r;
            strbS3_r    <= strbS2_r;
            dataS1_r[0] <= adcSampA;
            dataS1_r[1] <= adcSampB;
            dataS2_r    <= dataS1_r;
        end
    end

    assign sampTick = strbS2_r & ~strbS3_r;

    // ****************************************
    // Packing into words
    // ****************************************
    logic             phase_r;
    logic [ADC_W-1:0] half_r [NCH];
    logic [NCH-1:0]   pend_r;
    logic [WORD_W-1:0] packW_r [NCH];
    logic [NCH-1:0]   adcInRdy;
    logic [NCH-1:0]   adcOutVal;
    logic [WORD_W-1:0] adcOut [NCH];
    logic             capPop;

    // A pending word that is not taken before the next pair is a lost pair
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_r     <= 1'b0;
            pend_r      <= '0;
            adcOverflow <= 1'b0;
        end else if (clkEn) begin
            for (int ch = 0; ch < NCH; ch++) begin
                if (pend_r[ch] && adcInRdy[ch]) begin
                    pend_r[ch] <= 1'b0;
                end
                if (sampTick && !phase_r) begin
                    half_r[ch] <= dataS2_r[ch];
                end
                if (sampTick && phase_r) begin
                    packW_r[ch] <= {4'h0, dataS2_r[ch], 4'h0, half_r[ch]};
                    pend_r[ch]  <= 1'b1;
                    if (pend_r[ch] && !adcInRdy[ch]) begin
                        adcOverflow <= 1'b1;
                    end
                end
            end
            if (sampTick) begin
                phase_r <= ~phase_r;
            end
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : gAdc
        bfps_fifo #(.W(WORD_W), .DEPTH(DEPTH)) uAdcFifo (
            .clk      (clk),
            .srst     (srst),
            .clkEn    (clkEn),
            .inValid  (pend_r[g]),
            .inReady  (adcInRdy[g]),
            .inData   (packW_r[g]),
            .outValid (adcOutVal[g]),
            .outReady (capPop),
            .outData  (adcOut[g])
        );
    end

    // ****************************************
    // Sample banks, double buffered
    // ****************************************
    logic [WORD_W-1:0] sampMem_r [NCH][NBANK*NWORDS];
    logic [NBANK-1:0]  bankFull_r;
    logic              capBank_r;
    logic [IDX_W-1:0]  capAddr_r;
    logic              procBank_r;
    logic              bankRelease;
    bfps_st_t          st_r;

    // Both channels drain together, one word each per cycle, while the capture bank is free
    assign capPop = (&adcOutVal) & ~bankFull_r[capBank_r];

    always_ff @(posedge clk) begin
        if (clkEn && capPop) begin
            for (int ch = 0; ch < NCH; ch++) begin
                sampMem_r[ch][memIdx(capBank_r, capAddr_r)] <= adcOut[ch];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bankFull_r <= '0;
            capBank_r  <= 1'b0;
            capAddr_r  <= '0;
        end else if (clkEn) begin
            if (bankRelease) begin
                bankFull_r[procBank_r] <= 1'b0;
            end
            if (capPop) begin
                if (capAddr_r == IDX_W'(NWORDS-1)) begin
                    bankFull_r[capBank_r] <= 1'b1;
                    capBank_r             <= ~capBank_r;
                    capAddr_r             <= '0;
                end else begin
                    capAddr_r <= capAddr_r + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Delay tables
    // ****************************************
    logic [IDX_W-1:0]  crsTbl_r  [NCH][NPIX];
    logic [WORD_W-1:0] fineTbl_r [NCH][NPIX];

    always_ff @(posedge clk) begin
        if (clkEn && tblWe && !tblLocked && (int'(tbl.addr) < NPIX)) begin
            if (tbl.fine) begin
                fineTbl_r[tbl.chan][tbl.addr] <= tbl.data;
            end else begin
                crsTbl_r[tbl.chan][tbl.addr] <= tbl.data[IDX_W-1:0];
            end
        end
    end

    // ****************************************
    // Pixel loop
    // ****************************************
    logic [IDX_W-1:0]  pixIdx_r;
    logic [WORD_W-1:0] sampR_r [NCH];
    logic [WORD_W-1:0] fineR_r [NCH];
    logic [NCH-1:0]    conInRdy;
    logic [NCH-1:0]    conOutVal;
    logic [WORD_W-1:0] conOut [NCH];
    logic              conPush;
    logic [31:0]       frameCnt_r;
    logic              fire1;
    logic              fire2;

    assign conPush     = (st_r == ST_ROT) & (&conInRdy);
    assign bankRelease = clkEn & (st_r == ST_DONE);
    assign frameBusy   = (st_r != ST_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r       <= ST_IDLE;
            pixIdx_r   <= '0;
            procBank_r <= 1'b0;
            tblLocked  <= 1'b0;
        end else if (clkEn) begin
            case (st_r)
                ST_IDLE: begin
                    if (bankFull_r[procBank_r]) begin
                        st_r      <= ST_FETCH;
                        pixIdx_r  <= '0;
                        tblLocked <= 1'b1;
                    end
                end
                ST_FETCH: begin
                    for (int ch = 0; ch < NCH; ch++) begin
                        sampR_r[ch] <= sampMem_r[ch][memIdx(procBank_r, crsTbl_r[ch][pixIdx_r])];
                        fineR_r[ch] <= fineTbl_r[ch][pixIdx_r];
                    end
                    st_r <= ST_ROT;
                end
                ST_ROT: begin
                    if (conPush) begin
                        if (pixIdx_r == IDX_W'(NPIX-1)) begin
                            st_r <= ST_DONE;
                        end else begin
                            pixIdx_r <= pixIdx_r + 1'b1;
                            st_r     <= ST_FETCH;
                        end
                    end
                end
                ST_DONE: begin
                    procBank_r <= ~procBank_r;
                    st_r       <= ST_IDLE;
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Flags a frame whose pixel loop outlasts the frame period
    always_ff @(posedge clk) begin
        if (srst) begin
            frameCnt_r   <= '0;
            frameOverrun <= 1'b0;
        end else if (clkEn) begin
            if (st_r == ST_IDLE) begin
                frameCnt_r <= '0;
            end else begin
                frameCnt_r <= frameCnt_r + 1'b1;
                if (frameCnt_r == 32'(FRAME_CYCLES)) begin
                    frameOverrun <= 1'b1;
                end
            end
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : gCon
        bfps_fifo #(.W(WORD_W), .DEPTH(DEPTH)) uConFifo (
            .clk      (clk),
            .srst     (srst),
            .clkEn    (clkEn),
            .inValid  (conPush),
            .inReady  (conInRdy[g]),
            .inData   (rotate(sampR_r[g], fineR_r[g])),
            .outValid (conOutVal[g]),
            .outReady (g == 0 ? fire2 : fire1),
            .outData  (conOut[g])
        );
    end

    // ****************************************
    // Summing stages
    // ****************************************
    bfps_pix_t        upOut;
    bfps_pix_t        partIn;
    bfps_pix_t        partOut;
    logic             upOutVal;
    logic             partInRdy;
    logic             partOutVal;
    logic [IDX_W-1:0] sum1Idx_r;
    bfps_cplx_t       con0;
    bfps_cplx_t       con1;

    assign con0 = conOut[0];
    assign con1 = conOut[1];

    bfps_fifo #(.W($bits(bfps_pix_t)), .DEPTH(DEPTH)) uUpFifo (
        .clk      (clk),
        .srst     (srst),
        .clkEn    (clkEn),
        .inValid  (upValid),
        .inReady  (upReady),
        .inData   (upPix),
        .outValid (upOutVal),
        .outReady (fire1),
        .outData  (upOut)
    );

    assign fire1       = upOutVal & conOutVal[1] & partInRdy;
    assign partIn.first = (sum1Idx_r == '0);
    assign partIn.pix   = satAdd(upOut.pix, con1.i);

    // Pixel order is kept by counting, the upstream marker only cross-checks it
    always_ff @(posedge clk) begin
        if (srst) begin
            sum1Idx_r <= '0;
            alignErr  <= 1'b0;
        end else if (clkEn && fire1) begin
            sum1Idx_r <= (sum1Idx_r == IDX_W'(NPIX-1)) ? '0 : sum1Idx_r + 1'b1;
            if (upOut.first != (sum1Idx_r == '0)) begin
                alignErr <= 1'b1;
            end
        end
    end

    bfps_fifo #(.W($bits(bfps_pix_t)), .DEPTH(DEPTH)) uPartFifo (
        .clk      (clk),
        .srst     (srst),
        .clkEn    (clkEn),
        .inValid  (fire1),
        .inReady  (partInRdy),
        .inData   (partIn),
        .outValid (partOutVal),
        .outReady (fire2),
        .outData  (partOut)
    );

    assign fire2 = clkEn & partOutVal & conOutVal[0] & (~dnValid | dnReady);

    always_ff @(posedge clk) begin
        if (srst) begin
            dnValid <= 1'b0;
            dnPix   <= '0;
        end else if (clkEn) begin
            if (fire2) begin
                dnValid   <= 1'b1;
                dnPix.first <= partOut.first;
                dnPix.pix   <= satAdd(partOut.pix, con0.i);
            end else if (dnReady) begin
                dnValid <= 1'b0;
            end
        end
    end
endmodule

// ### verif/bfps_node_monitor.sv
// Port-level checker for the pixel sum node
`timescale 1ns/100ps
module bfps_node_mon #(
    parameter int FRAME_CYCLES = 20000,
    parameter int DEPTH        = 4
) (
    input wire logic                clk,
    input wire logic                srst,
    input wire logic                clkEn,
    input wire logic                upValid,
    input wire logic                upReady,
    input wire logic                dnValid,
    input wire logic                dnReady,
    input wire bfps_pkg::bfps_pix_t dnPix,
    input wire logic                adcOverflow,
    input wire logic                alignErr,
    input wire logic                frameOverrun,
    input wire logic                tblLocked,
    input wire logic                frameBusy
);
    import bfps_pkg::*;
    logic [31:0] upCnt_r;
    logic [31:0] dnCnt_r;
    logic [31:0] busyCnt_r;
    logic        wasBusy_r;
    logic [12:0] outIdx_r;
    // ****************************************
    // Helper counters
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            upCnt_r <= '0;
            dnCnt_r <= '0;
            outIdx_r <= '0;
        end else if (clkEn) begin
            if (upValid && upReady) upCnt_r <= upCnt_r + 1;
            if (dnValid && dnReady) dnCnt_r <= dnCnt_r + 1;
            if (dnValid && dnReady) outIdx_r <= (outIdx_r == 13'(NPIX - 1)) ? '0 : outIdx_r + 1'b1;
        end
    end
    // Count kept after the loop ends so late flags can still be judged
    always_ff @(posedge clk) begin
        if (srst) begin
            busyCnt_r <= '0;
            wasBusy_r <= 1'b0;
        end else if (clkEn) begin
            wasBusy_r <= frameBusy;
            if (frameBusy) busyCnt_r <= wasBusy_r ? busyCnt_r + 1 : 32'h0000_0001;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_dn_hold_stall: assert property (dnValid && !dnReady |=> dnValid && $stable(dnPix))
        else $error("downstream pixel dropped or changed while stalled");
    a_adc_flag_sticky: assert property (adcOverflow |=> adcOverflow)
        else $error("converter overflow flag cleared");
    a_align_sticky: assert property (alignErr |=> alignErr)
        else $error("alignment flag cleared");
    a_lock_sticky: assert property (tblLocked |=> tblLocked)
        else $error("table lock released");
    a_busy_locks: assert property ($rose(frameBusy) |-> ##[0:1] tblLocked)
        else $error("pixel loop running with tables unlocked");
    a_overrun_late: assert property ($rose(frameOverrun) |-> busyCnt_r >= FRAME_CYCLES - 1)
        else $error("overrun flagged too early");
    a_overrun_due: assert property (frameBusy && busyCnt_r > FRAME_CYCLES + 4 |-> frameOverrun)
        else $error("overrun not flagged");
    a_first_marks: assert property (dnValid && dnReady |-> dnPix.first == (outIdx_r == '0))
        else $error("first marker on wrong pixel");
    a_dn_after_up: assert property (dnValid |-> upCnt_r > dnCnt_r)
        else $error("output pixel without upstream pixel");
    a_reset_quiet: assert property ($past(srst) |-> !dnValid && !frameBusy && !tblLocked && upReady)
        else $error("outputs not idle after reset");
    a_frame_len: assert property ($fell(frameBusy) |-> busyCnt_r >= 2 * NPIX)
        else $error("pixel loop ended too soon");
endmodule

bind bfps_node bfps_node_mon #(.FRAME_CYCLES(FRAME_CYCLES), .DEPTH(DEPTH)) mon (.*);

// ### verif/bfps_peer_model.sv
// Upstream image source and downstream image sink around the node
`timescale 1ns/100ps
module bfps_peer_model (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                clkEn,
    input  wire logic                slowUp,
    input  wire logic                slowDn,
    output logic                     upValid,
    input  wire logic                upReady,
    output bfps_pkg::bfps_pix_t      upPix,
    input  wire logic                dnValid,
    output logic                     dnReady,
    input  wire bfps_pkg::bfps_pix_t dnPix,
    output logic [12:0]              srcIdx,
    input  wire logic [15:0]         srcPix,
    output logic                     sinkStb,
    output bfps_pkg::bfps_pix_t      sinkPix,
    output logic [12:0]              sinkIdx
);
    import bfps_pkg::*;
    logic [12:0] idx_r;
    logic [12:0] rxCnt_r;
    logic        fire;
    assign fire   = upValid && upReady;
    assign srcIdx = fire ? idx_r + 13'h1 : idx_r;
    // Held until taken; idle bus shows a changing pattern, not the last pixel
    always_ff @(posedge clk) begin
        if (srst) begin
            upValid <= 1'b0;
            upPix <= '0;
            idx_r <= '0;
        end else if (clkEn) begin
            if (fire) idx_r <= srcIdx;
            if ((fire || !upValid) && !slowUp && srcIdx < 13'(NPIX)) begin
                upValid <= 1'b1;
                upPix <= '{first: srcIdx == '0, pix: srcPix};
            end else if (fire || !upValid) begin
                upValid <= 1'b0;
                upPix <= ~upPix;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            dnReady <= 1'b0;
            sinkStb <= 1'b0;
            sinkPix <= '0;
            sinkIdx <= '0;
            rxCnt_r <= '0;
        end else if (clkEn) begin
            dnReady <= !slowDn;
            sinkStb <= dnValid && dnReady;
            if (dnValid && dnReady) begin
                sinkPix <= dnPix;
                sinkIdx <= rxCnt_r;
                rxCnt_r <= rxCnt_r + 1;
            end
        end
    end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the pixel sum node
`timescale 1ns/100ps
module testbench;
    import bfps_pkg::*;
    localparam int XTRA = 2000;
    logic                clk, srst, clkEn, adcStrobe, tblWe, slowUp, slowDn;
    logic                upValid, upReady, dnValid, dnReady, sinkStb;
    logic                adcOverflow, alignErr, frameOverrun, tblLocked, frameBusy;
    logic [11:0]         adcSampA, adcSampB;
    logic [12:0]         srcIdx, sinkIdx;
    logic [15:0]         srcPix;
    logic [31:0]         lfsr, rnd;
    bfps_tbl_t           tbl;
    bfps_pix_t           upPix, dnPix, sinkPix;
    logic [11:0]         sampA [NPOINTS];
    logic [11:0]         sampB [NPOINTS];
    logic [12:0]         crs [2][NPIX];
    logic [31:0]         fin [2][NPIX];
    logic [15:0]         upImg [NPIX];
    int                  num_errors, samples_checked;

    bfps_node #(.FRAME_CYCLES(FRAME_CYC), .DEPTH(FIFO_DEP)) dut (.*);
    bfps_peer_model peer (.*);
    assign srcPix = upImg[srcIdx];

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] nextRand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [15:0] sat(input longint v);
        return v > 32767 ? 16'h7fff : (v < -32768 ? 16'h8000 : v[15:0]);
    endfunction
    // Samples kept below bit 11 so pad and sign readings agree
    function automatic logic [15:0] rotI(input int ch, input int p);
        int     w;
        longint i, q, c, s;
        w = crs[ch][p] >= NPIX ? NPIX - 1 : crs[ch][p];
        i = ch ? sampB[2 * w] : sampA[2 * w];
        q = ch ? sampB[2 * w + 1] : sampA[2 * w + 1];
        c = $signed(fin[ch][p][31:16]);
        s = $signed(fin[ch][p][15:0]);
        return sat((i * c - q * s) >>> ROT_SHIFT);
    endfunction
    function automatic logic [15:0] expPix(input int p);
        logic [15:0] part;
        part = sat(longint'($signed(upImg[p])) + longint'($signed(rotI(1, p))));
        return sat(longint'($signed(part)) + longint'($signed(rotI(0, p))));
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic writeTbl(input logic f, input logic c, input logic [12:0] a, input logic [31:0] d);
        tblWe = 1'b1;
        tbl = '{fine: f, chan: c, addr: a, data: d};
        @(negedge clk);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        rnd = nextRand();
        slowUp <= rnd[0] & rnd[1];
        slowDn <= rnd[2] & rnd[3];
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        lfsr = 32'h0000_f945;
        {srst, clkEn} = 2'b11;
        {adcStrobe, tblWe, slowUp, slowDn} = 4'h0;
        {adcSampA, adcSampB, tbl} = '0;
        num_errors = 0;
        samples_checked = 0;
        for (int n = 0; n < NPOINTS; n++) begin
            sampA[n] = 12'(nextRand()) & 12'h7ff;
            sampB[n] = 12'(nextRand()) & 12'h7ff;
        end
        for (int p = 0; p < NPIX; p++) begin
            crs[0][p] = 13'(nextRand() % NPIX);
            crs[1][p] = 13'(nextRand() % NPIX);
            fin[0][p] = nextRand();
            fin[1][p] = nextRand();
            upImg[p] = 16'(nextRand());
        end
        crs[0][0] = 13'h1fff;
        crs[1][1] = 13'(NPIX - 1);
        fin[0][3] = 32'h8000_8000;
        fin[1][3] = 32'h7fff_0000;
        upImg[1] = 16'h7fff;
        upImg[2] = 16'h8000;
        repeat (6) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        check("tblLocked", tblLocked, 32'h0);
        check("frameBusy", frameBusy, 32'h0);
        fork
            for (int n = 0; n < NPOINTS + XTRA; n++) begin
                adcStrobe = 1'b1;
                adcSampA = n < NPOINTS ? sampA[n] : 12'(nextRand()) & 12'h7ff;
                adcSampB = n < NPOINTS ? sampB[n] : 12'(nextRand()) & 12'h7ff;
                repeat (2) @(negedge clk);
                adcStrobe = 1'b0;
                repeat (3) @(negedge clk);
            end
            begin : tables
                for (int f = 0; f < 2; f++)
                    for (int c = 0; c < 2; c++)
                        for (int p = 0; p < NPIX; p++)
                            writeTbl(f[0], c[0], 13'(p), f ? fin[c][p] : 32'(crs[c][p]));
                tblWe = 1'b0;
                for (int t = 0; t < 90000 && !frameBusy; t++) @(negedge clk);
                check("frameStart", frameBusy, 32'h1);
                writeTbl(1'b0, 1'b0, 13'(NPIX - 1), 32'h0000_0000);
                writeTbl(1'b1, 1'b1, 13'(NPIX - 1), 32'h0000_0000);
                tblWe = 1'b0;
            end
            begin : sink
                int got, t;
                got = 0;
                t = 0;
                while (got < NPIX && t < 95000) begin
                    @(negedge clk);
                    t++;
                    if (sinkStb) begin
                        check("pixIdx", sinkIdx, got);
                        check("dnPix", sinkPix, {sinkIdx == 0, expPix(sinkIdx)});
                        got++;
                    end
                end
                check("pixCount", got, NPIX);
            end
        join
        check("adcOverflow", adcOverflow, 32'h0);
        check("alignErr", alignErr, 32'h0);
        check("frameOverrun", frameOverrun, 32'h0);
        check("tblLocked", tblLocked, 32'h1);
        check("frameBusy", frameBusy, 32'h0);
        results();
    end
endmodule
